// [verilog/sarc_rx.sv]
// Serial audio receiver control: registers, clock pins, frame sync and receive shifters
`timescale 1ns/1ns
`include "sarc_map.svh"

module sarc_rx #(
    parameter int NUM_RX = 4                   // Receivers sharing transmitter pins
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         sw_reset_i,      // Software reset pulse
    input  wire logic         psel_i,
    input  wire logic         penable_i,
    input  wire logic         pwrite_i,
    input  wire logic [31:0]  paddr_i,
    input  wire logic [31:0]  pwdata_i,
    output logic      [31:0]  prdata_o,
    output logic              pready_o,
    output logic              pslverr_o,
    input  wire logic [3:0]   tx_enable_i,     // Bit n: transmitter n enabled
    input  wire logic         tx_bit_clock_i,  // Transmitter bit clock, sync mode
    input  wire logic         tx_frame_sync_i, // Transmitter frame sync, sync mode
    input  wire logic         tx_buffer_enable_i,
    input  wire logic [3:0]   shared_data_pin_i,
    input  wire logic         rx_bit_clock_pin_i,
    output logic              rx_bit_clock_pin_o,
    output logic              rx_bit_clock_pin_oe_o,
    input  wire logic         rx_frame_sync_pin_i,
    output logic              rx_frame_sync_pin_o,
    output logic              rx_frame_sync_pin_oe_o,
    input  wire logic         rx_high_freq_clock_pin_i,
    output logic              rx_high_freq_clock_pin_o,
    output logic              rx_high_freq_clock_pin_oe_o
);

    // The state struct holds exactly four receivers
    if (NUM_RX != sarc_pkg::SARC_NUM_RX)
    begin : g_bad_num_rx
        $error("sarc_rx supports exactly four receivers");
    end

    sarc_pkg::sarc_state_type r;               // Registered state
    sarc_pkg::sarc_state_type n;               // Next state

    // Decoded configuration
    logic        sync_mode;                    // Synchronous mode
    logic        ckp;                          // Bit clock polarity
    logic        fsp;                          // Frame sync polarity
    logic [1:0]  mode;                         // Network mode field
    logic [4:0]  rdc;                          // Frame rate divider
    logic [5:0]  sl;                           // Slot length
    logic [4:0]  wl;                           // Word length
    logic        sws_ok;                       // Slot word code is legal
    logic [5:0]  first;                        // First word bit within slot
    logic [4:0]  pad_sh;                       // Zero bits padded on the right
    logic        bclk;                         // Bit clock seen by receivers
    logic        fs_act;                       // Frame sync at active level
    logic        latch;                        // Receive latch edge this cycle
    logic        start;                        // Frame start at this latch edge
    logic [5:0]  cur_pos;                      // Bit position of current bit
    logic [4:0]  cur_slot;                     // Slot of current bit
    logic        slot_ok;                      // Current slot carries a word
    logic        acc;                          // APB access phase
    logic [23:0] idx;                          // Register index of access
    logic        hit;                          // Address maps to a register
    logic [31:0] rd_mux;                       // Read value of addressed register

    // Slot and word length decode; illegal codes transfer nothing
    function automatic logic [11:0] sws_decode(input logic [4:0] c);
        logic [11:0] v;
        v = 12'h000;
        unique case (c)
            5'h00:   v = {1'b1, 6'd8,  5'd8};
            5'h04:   v = {1'b1, 6'd12, 5'd8};
            5'h01:   v = {1'b1, 6'd12, 5'd12};
            5'h08:   v = {1'b1, 6'd16, 5'd8};
            5'h05:   v = {1'b1, 6'd16, 5'd12};
            5'h02:   v = {1'b1, 6'd16, 5'd16};
            5'h0C:   v = {1'b1, 6'd20, 5'd8};
            5'h09:   v = {1'b1, 6'd20, 5'd12};
            5'h06:   v = {1'b1, 6'd20, 5'd16};
            5'h03:   v = {1'b1, 6'd20, 5'd20};
            5'h10:   v = {1'b1, 6'd24, 5'd8};
            5'h0D:   v = {1'b1, 6'd24, 5'd12};
            5'h0A:   v = {1'b1, 6'd24, 5'd16};
            5'h07:   v = {1'b1, 6'd24, 5'd20};
            5'h18:   v = {1'b1, 6'd32, 5'd8};
            5'h15:   v = {1'b1, 6'd32, 5'd12};
            5'h12:   v = {1'b1, 6'd32, 5'd16};
            5'h0F:   v = {1'b1, 6'd32, 5'd20};
            5'h1F:   v = {1'b1, 6'd32, 5'd24};
            default: v = 12'h000;               // Reserved codes
        endcase
        return v;
    endfunction

    // Configuration decode shared by generator and receivers
    always_comb
    begin
        sync_mode           = r.ccr[`SARC_CCR_SYNC];
        ckp                 = r.rx_clk[`SARC_RXCLK_CKP];
        fsp                 = r.rx_clk[`SARC_RXCLK_FSP];
        mode                = r.rx_ctl[`SARC_RXCTL_MOD_LSB +: 2];
        rdc                 = r.rx_clk[`SARC_RXCLK_RDC_LSB +: 5];
        {sws_ok, sl, wl}    = sws_decode(r.rx_ctl[`SARC_RXCTL_SWS_LSB +: 5]);
        // Word sits at slot start or slot end
        first               = r.rx_ctl[`SARC_RXCTL_WA] ? (sl - {1'b0, wl}) : 6'h00;
        pad_sh              = 5'(`SARC_WORD_W) - wl;
        // Sync mode takes transmitter clock and frame sync
        if (sync_mode)
        begin
            bclk   = tx_bit_clock_i;
            fs_act = tx_frame_sync_i ^ fsp;
        end
        else
        begin
            // Internal generator or synchronised pin
            bclk   = r.rx_clk[`SARC_RXCLK_CKD] ? r.gen_clk : r.sync2[0];
            fs_act = r.rx_clk[`SARC_RXCLK_FSD] ? r.gen_fs : (r.sync2[1] ^ fsp);
        end
        // Latch on the edge opposite the drive edge
        latch    = (r.bclk_q != bclk) && (bclk == ckp);
        start    = fs_act && !r.fs_prev;
        cur_pos  = (start || r.pos == sl - 6'h01) ? 6'h00 : r.pos + 6'h01;
        cur_slot = start ? 5'h00 : ((r.pos == sl - 6'h01) ? r.slot + 5'h01 : r.slot);
        // Normal mode uses frame sync slot only; network every slot
        unique case (mode)
            `SARC_MOD_NORMAL:   slot_ok = (cur_slot == 5'h00);
            `SARC_MOD_RESERVED: slot_ok = 1'b0;
            default:            slot_ok = (rdc == 5'h00) || (cur_slot <= rdc);
        endcase
    end

    // APB decode and read mux
    always_comb
    begin
        acc    = psel_i && penable_i;
        idx    = paddr_i[25:2];
        hit    = (paddr_i[31:26] == 6'h00) && (paddr_i[1:0] == 2'h0) &&
                 (idx == `SARC_IDX_RXCTL || idx == `SARC_IDX_RXCLK || idx == `SARC_IDX_CCR ||
                  (!pwrite_i && (idx == `SARC_IDX_STAT || idx[23:2] == `SARC_IDX_DATA0 >> 2)));
        rd_mux = 32'h00000000;
        if (idx == `SARC_IDX_RXCTL)
        begin
            rd_mux = {8'h00, r.rx_ctl};
        end
        else if (idx == `SARC_IDX_RXCLK)
        begin
            rd_mux = {8'h00, r.rx_clk};
        end
        else if (idx == `SARC_IDX_CCR)
        begin
            rd_mux = {8'h00, r.ccr};
        end
        else if (idx == `SARC_IDX_STAT)
        begin
            // Input flags are meaningful in sync mode only
            rd_mux = {25'h0000000, r.sync2[2:0], r.full};
        end
        else if (idx[23:2] == `SARC_IDX_DATA0 >> 2)
        begin
            rd_mux = {8'h00, r.rxd[idx[1:0]]};
        end
        if (!hit)
        begin
            rd_mux = 32'h00000000;
        end
    end

    // Next state: bus writes, generator, receive shifters
    always_comb
    begin
        n = r;
        // Pin synchronisers: data pins, high freq, frame sync, bit clock
        n.sync1 = {shared_data_pin_i, rx_high_freq_clock_pin_i, rx_frame_sync_pin_i, rx_bit_clock_pin_i};
        n.sync2 = r.sync1;

        // Register writes; reserved receive control and common control bits never stored; receive clock control stored whole
        if (acc && pwrite_i && hit)
        begin
            if (idx == `SARC_IDX_RXCTL)
            begin
                n.rx_ctl = pwdata_i[23:0] & `SARC_RXCTL_WMASK;
            end
            if (idx == `SARC_IDX_RXCLK)
            begin
                n.rx_clk = pwdata_i[23:0];
            end
            if (idx == `SARC_IDX_CCR)
            begin
                n.ccr = pwdata_i[23:0] & `SARC_CCR_WMASK;
            end
        end
        // Read data captured in setup so access phase needs no wait
        if (psel_i && !penable_i)
        begin
            n.rdata = rd_mux;
        end
        // Reading a data register clears its flag; a new word wins below
        if (acc && !pwrite_i && idx[23:2] == `SARC_IDX_DATA0 >> 2)
        begin
            n.full[idx[1:0]] = 1'b0;
        end

        // Clock generator: prescaler makes high freq, divider makes bit clock
        if (r.pre_cnt >= r.rx_clk[`SARC_RXCLK_RPM_LSB +: 8])
        begin
            n.pre_cnt = 8'h00;
            n.gen_hf  = !r.gen_hf;
            if (r.gen_hf)
            begin
                if (r.hf_cnt >= r.rx_clk[`SARC_RXCLK_RFP_LSB +: 4])
                begin
                    n.hf_cnt  = 4'h0;
                    n.gen_clk = !r.gen_clk;
                    // Counters and frame sync move on the drive edge
                    if (n.gen_clk != ckp)
                    begin
                        n.gen_pos = (r.gen_pos >= sl - 6'h01) ? 6'h00 : r.gen_pos + 6'h01;
                        if (r.gen_pos >= sl - 6'h01)
                        begin
                            n.gen_slot = (r.gen_slot >= rdc) ? 5'h00 : r.gen_slot + 5'h01;
                        end
                        // Word long or one bit long frame sync
                        n.gen_fs = (n.gen_slot == 5'h00) &&
                                   (r.rx_ctl[`SARC_RXCTL_FSL] ? (n.gen_pos == 6'h00)
                                                         : (n.gen_pos < {1'b0, wl}));
                    end
                end
                else
                begin
                    n.hf_cnt = r.hf_cnt + 4'h1;
                end
            end
        end
        else
        begin
            n.pre_cnt = r.pre_cnt + 8'h01;
        end

        // Receivers act only at the latch edge
        n.bclk_q = bclk;
        if (latch)
        begin
            n.fs_prev = fs_act;
            if (start)
            begin
                n.in_frame = 1'b1;
                n.oflag    = r.ccr[`SARC_CCR_OF_LSB +: 3];
            end
            n.pos  = cur_pos;
            n.slot = cur_slot;
            for (int i = 0; i < sarc_pkg::SARC_NUM_RX; i++)
            begin
                if ((r.in_frame || start) && sws_ok && slot_ok)
                begin
                    // First word bit: arm only if enabled and pin not transmitting
                    if (cur_pos == first)
                    begin
                        n.armed[i] = r.rx_ctl[`SARC_RXCTL_RE_LSB + i] && !tx_enable_i[i];
                        n.shreg[i] = 24'h000000;
                    end
                    if (cur_pos >= first && cur_pos < first + {1'b0, wl})
                    begin
                        // MSB first shifts up from bit 0, LSB first down from bit 23
                        if (r.rx_ctl[`SARC_RXCTL_SHFD])
                        begin
                            n.shreg[i] = {r.sync2[3 + i], n.shreg[i][23:1]};
                        end
                        else
                        begin
                            n.shreg[i] = {n.shreg[i][22:0], r.sync2[3 + i]};
                        end
                    end
                    // Last word bit: transfer left aligned, zero padded
                    if (cur_pos == first + {1'b0, wl} - 6'h01 && n.armed[i])
                    begin
                        n.rxd[i]   = r.rx_ctl[`SARC_RXCTL_SHFD] ? n.shreg[i] : (n.shreg[i] << pad_sh);
                        n.full[i]  = 1'b1;
                        n.armed[i] = 1'b0;
                    end
                end
            end
        end

        // Software reset clears control registers
        if (sw_reset_i)
        begin
            n.rx_ctl = `SARC_RESET_VALUE;
            n.rx_clk = `SARC_RESET_VALUE;
            n.ccr  = `SARC_RESET_VALUE;
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end

    // Pin muxing; sync mode turns receiver clock pins into flags
    always_comb
    begin
        pready_o                    = 1'b1;
        pslverr_o                   = psel_i && penable_i && !hit;
        prdata_o                    = r.rdata;
        rx_bit_clock_pin_oe_o       = r.rx_clk[`SARC_RXCLK_CKD];
        rx_bit_clock_pin_o          = sync_mode ? r.oflag[0] : r.gen_clk;
        // Buffer set with direction clear is reserved; keep the pin an input
        rx_frame_sync_pin_oe_o      = r.rx_clk[`SARC_RXCLK_FSD];
        rx_frame_sync_pin_o         = sync_mode ? (r.ccr[`SARC_CCR_XBUF] ? tx_buffer_enable_i : r.oflag[1])
                                                : (r.gen_fs ^ fsp);
        rx_high_freq_clock_pin_oe_o = r.rx_clk[`SARC_RXCLK_HCKD];
        rx_high_freq_clock_pin_o    = sync_mode ? r.oflag[2]
                                                : (r.gen_hf ^ r.rx_clk[`SARC_RXCLK_HCKP]);
    end

    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    logic [23:0] pad_mask;                     // Bits that must be zero after padding
    assign pad_mask = 24'hFFFFFF >> (5'(`SARC_WORD_W) - pad_sh);

    sequence seq_sw_reset;
        sw_reset_i;
    endsequence
    sequence seq_regs_clear;
        r.rx_ctl == 24'h000000 && r.rx_clk == 24'h000000 && r.ccr == 24'h000000;
    endsequence

    AST_SW_RESET_CLEARS: assert property (seq_sw_reset |=> seq_regs_clear)
        else $error("software reset left control bits set");
    AST_RESERVED_ZERO: assert property (r.rx_ctl[5:4] == 2'h0 && r.rx_ctl[18:17] == 2'h0)
        else $error("reserved receive control bits not zero");
    AST_BCLK_DIR: assert property (rx_bit_clock_pin_oe_o == r.rx_clk[`SARC_RXCLK_CKD])
        else $error("bit clock pin direction wrong");
    AST_FLAG_ZERO: assert property (sync_mode && rx_bit_clock_pin_oe_o |-> rx_bit_clock_pin_o == r.oflag[0])
        else $error("output flag zero not on bit clock pin");
    AST_BUFFER_ENABLE: assert property (sync_mode && r.ccr[`SARC_CCR_XBUF] && rx_frame_sync_pin_oe_o
                                        |-> rx_frame_sync_pin_o == tx_buffer_enable_i)
        else $error("buffer enable not on frame sync pin");
    AST_HF_DIR: assert property (!sync_mode && !r.rx_clk[`SARC_RXCLK_HCKD] |-> !rx_high_freq_clock_pin_oe_o)
        else $error("high freq pin driven while input");
    AST_PAD: assert property ($rose(r.full[0]) && !r.rx_ctl[`SARC_RXCTL_SHFD] |-> (r.rxd[0] & pad_mask) == 24'h000000)
        else $error("short word not zero padded");
    AST_ARM_ENABLED: assert property ($rose(r.armed[1]) |-> $past(r.rx_ctl[`SARC_RXCTL_RE_LSB + 1] && !tx_enable_i[1]))
        else $error("receiver armed while disabled or pin transmitting");
    AST_GEN_FS_EDGE: assert property ($changed(r.gen_fs) |-> $changed(r.gen_clk) && r.gen_clk != ckp)
        else $error("generated frame sync moved off drive edge");
    AST_RESERVED_MODE: assert property (mode == `SARC_MOD_RESERVED |=> !$rose(r.full[2]))
        else $error("transfer in reserved mode");

endmodule // sarc_rx

// [verilog/sarc_map.svh]
// Register map, field positions and reset values of the serial audio receiver control block
// Behaviour
// - Bit clock polarity swaps drive and latch edges
// - Frame sync polarity picks active level
// - High frequency clock polarity swaps edges likewise
// - Async: bit clock direction selects internal generator
// - Sync: bit clock pin is flag zero
// - Async: frame sync direction selects internal generator
// - Sync: frame sync pin flag or buffer enable
// - Async: high frequency clock direction selects generator
// - Sync: high frequency clock pin is flag two
// - Hardware and software reset clear receive control
// - Receiver samples only when enabled, transmitter off
// - Reserved receive control bits read zero
// - Shift direction selects MSB or LSB first
// - Alignment picks word at slot start or end
// - Short words padded with zeros on right
// - Network mode field selects operating mode
// - Normal: one word per frame; network: every slot
// - Slot word select decodes lengths, first ten
// - Slot word select decodes remaining lengths
// - Frame sync length: whole word or one bit
// - Sync mode shares transmitter clock and frame sync
// - Network frame holds divider plus one words
`ifndef SARC_MAP_SVH
`define SARC_MAP_SVH

// Register indices; byte address is four times the index
`define SARC_IDX_RXCTL      24'hFFFFB7
`define SARC_IDX_RXCLK      24'hFFFFB8
`define SARC_IDX_CCR        24'hFFFFB4
`define SARC_IDX_STAT       24'hFFFFB0
`define SARC_IDX_DATA0      24'hFFFFA0
`define SARC_RESET_VALUE    24'h000000

// Receive control fields
`define SARC_RXCTL_RE_LSB   0
`define SARC_RXCTL_SHFD     6
`define SARC_RXCTL_WA       7
`define SARC_RXCTL_MOD_LSB  8
`define SARC_RXCTL_SWS_LSB  10
`define SARC_RXCTL_FSL      15
`define SARC_RXCTL_WMASK    24'hF9FFCF

// Receive clock control fields
`define SARC_RXCLK_RPM_LSB  0
`define SARC_RXCLK_RDC_LSB  9
`define SARC_RXCLK_RFP_LSB  14
`define SARC_RXCLK_CKP      18
`define SARC_RXCLK_FSP      19
`define SARC_RXCLK_HCKP     20
`define SARC_RXCLK_CKD      21
`define SARC_RXCLK_FSD      22
`define SARC_RXCLK_HCKD     23

// Common control fields
`define SARC_CCR_OF_LSB     0
`define SARC_CCR_SYNC       6
`define SARC_CCR_XBUF       7
`define SARC_CCR_WMASK      24'h0000C7

// Status fields
`define SARC_STAT_IF_LSB    4

// Mode codes and word width
`define SARC_MOD_NORMAL     2'h0
`define SARC_MOD_NETWORK    2'h1
`define SARC_MOD_RESERVED   2'h2
`define SARC_WORD_W         24

`endif

// [verilog/sarc_pkg.sv]
// Types shared by the serial audio receiver control block
package sarc_pkg;

    localparam int SARC_NUM_RX = 4;

    // Whole register state of the receiver control block
    typedef struct packed {
        logic [23:0]       rx_ctl;     // Receive control
        logic [23:0]       rx_clk;     // Receive clock control
        logic [23:0]       ccr;        // Common control
        logic [31:0]       rdata;      // Read data held for access phase
        logic [6:0]        sync1;      // Pin synchroniser, first stage
        logic [6:0]        sync2;      // Pin synchroniser, second stage
        logic [7:0]        pre_cnt;    // Prescaler count
        logic [3:0]        hf_cnt;     // High frequency to bit clock divider
        logic              gen_hf;     // Generated high frequency clock
        logic              gen_clk;    // Generated bit clock
        logic [5:0]        gen_pos;    // Generator bit within slot
        logic [4:0]        gen_slot;   // Generator slot within frame
        logic              gen_fs;     // Generated frame sync, active high
        logic              bclk_q;     // Previous receive bit clock level
        logic              fs_prev;    // Frame sync at previous latch edge
        logic              in_frame;   // A frame sync has been seen
        logic [5:0]        pos;        // Receive bit within slot
        logic [4:0]        slot;       // Receive slot within frame
        logic [3:0][23:0]  shreg;      // Receive shift registers
        logic [3:0][23:0]  rxd;        // Receive data registers
        logic [3:0]        armed;      // Word in progress will transfer
        logic [3:0]        full;       // Data register holds a new word
        logic [2:0]        oflag;      // Output flags latched at frame start
    } sarc_state_type;

endpackage

// [verification/sarc_codec_model.sv]
// Behavioural serial audio codec driving bit clock, frame sync and data
`timescale 1ns/1ns

module sarc_codec_model (
    input  wire logic clk_i,
    output logic      bclk_o,   // Stands low between frames
    output logic      fs_o,     // Frame sync line
    output logic      data_o    // Serial data line
);
    initial
    begin
        bclk_o = 1'b0;
        fs_o   = 1'b0;
        data_o = 1'b0;
    end

    // One lead-in bit with sync idle, then an eight bit word, first bit with sync
    task automatic send(input logic [7:0] w, input logic inv);
        for (int i = -1; i < 8; i++)
        begin
            repeat (4) @(posedge clk_i);
            bclk_o <= 1'b1;
            fs_o   <= (i == 0) ^ inv;
            data_o <= (i < 0) ? ~data_o : w[7 - i];
            repeat (4) @(posedge clk_i);
            bclk_o <= 1'b0;
        end
        // Line released: inverse of last value so a stale bit cannot pass
        repeat (4) @(posedge clk_i);
        data_o <= ~data_o;
    endtask
endmodule // sarc_codec_model

// [verification/sarc_rx_tb.sv]
// Self-checking bench: APB register access, pin directions and word reception
`timescale 1ns/1ns
`include "sarc_map.svh"

module sarc_rx_tb;
    logic        clk_i = 1'b0, rst_n_i = 1'b0, sw_reset = 1'b0, tx_buf = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pslverr, pready;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic [3:0]  tx_enable = 4'h0;
    logic [2:0]  oe, po;
    logic        bclk, fs, sd, err;
    int          n_fail = 0, total_checks = 0;

    always #2 clk_i = ~clk_i;

    sarc_codec_model codec (.clk_i(clk_i), .bclk_o(bclk), .fs_o(fs), .data_o(sd));

    sarc_rx dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sw_reset_i(sw_reset), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .tx_enable_i(tx_enable), .tx_bit_clock_i(bclk),
        .tx_frame_sync_i(fs), .tx_buffer_enable_i(tx_buf), .shared_data_pin_i({4{sd}}),
        .rx_bit_clock_pin_i(bclk), .rx_bit_clock_pin_o(po[0]), .rx_bit_clock_pin_oe_o(oe[0]),
        .rx_frame_sync_pin_i(fs), .rx_frame_sync_pin_o(po[1]), .rx_frame_sync_pin_oe_o(oe[1]),
        .rx_high_freq_clock_pin_i(1'b0), .rx_high_freq_clock_pin_o(po[2]),
        .rx_high_freq_clock_pin_oe_o(oe[2]));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [23:0] idx, input logic [31:0] wd);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {6'h00, idx, 2'h0};
        pwdata <= wd;
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rdchk(input logic [23:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask

    task automatic stop_test;
        if (n_fail == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Watchdog well beyond the few microseconds the sequence needs
    initial
    begin
        #100000;
        n_fail++;
        stop_test();
    end

    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        rdchk(`SARC_IDX_RXCTL, 32'h0);
        rdchk(`SARC_IDX_RXCLK, 32'h0);
        apb(1'b1, `SARC_IDX_RXCTL, 32'hFFFFFFFF);
        rdchk(`SARC_IDX_RXCTL, 32'h00F9FFCF);
        sw_reset <= 1'b1;
        @(posedge clk_i);
        sw_reset <= 1'b0;
        @(posedge clk_i);
        rdchk(`SARC_IDX_RXCTL, 32'h0);
        apb(1'b1, `SARC_IDX_RXCTL + 24'h2, 32'h1);
        chk({31'h0, err}, 32'h1);
        rdchk(`SARC_IDX_RXCTL + 24'h2, 32'h0);
        // Async: every direction bit set drives all three pins
        apb(1'b1, `SARC_IDX_RXCLK, 32'h00E00000);
        chk({29'h0, oe}, 32'h7);
        // Sync with buffer enable: frame sync pin carries the buffer enable
        tx_buf <= 1'b1;
        apb(1'b1, `SARC_IDX_CCR, 32'h000000C0);
        chk({29'h0, oe}, 32'h7);
        chk({31'h0, po[1]}, 32'h1);
        // Output flags reach the pins at the transmitter frame start
        apb(1'b1, `SARC_IDX_CCR, 32'h000000C5);
        codec.send(8'h00, 1'b0);
        chk({30'h0, po[2], po[0]}, 32'h3);
        apb(1'b1, `SARC_IDX_RXCLK, 32'h0);
        chk({29'h0, oe}, 32'h0);
        apb(1'b1, `SARC_IDX_CCR, 32'h0);
        // Receiver 1 enabled while its transmitter runs: it must not capture
        tx_enable <= 4'h2;
        apb(1'b1, `SARC_IDX_RXCTL, 32'h3);
        codec.send(8'hA5, 1'b0);
        repeat (10) @(posedge clk_i);
        rdchk(`SARC_IDX_STAT, 32'h1);
        rdchk(`SARC_IDX_DATA0, 32'h00A50000);
        rdchk(`SARC_IDX_DATA0 + 24'h1, 32'h0);
        // Transmitter off first, then two receivers; low-active sync, LSB first
        tx_enable <= 4'h0;
        apb(1'b1, `SARC_IDX_RXCLK, 32'h00080000);
        apb(1'b1, `SARC_IDX_RXCTL, 32'h43);
        codec.send(8'h35, 1'b1);
        repeat (10) @(posedge clk_i);
        rdchk(`SARC_IDX_DATA0, 32'h00AC0000);
        rdchk(`SARC_IDX_DATA0 + 24'h1, 32'h00AC0000);
        // Reserved mode: no receiver transfers; only the frame sync flag shows
        apb(1'b1, `SARC_IDX_RXCTL, 32'h20F);
        codec.send(8'hFF, 1'b1);
        repeat (10) @(posedge clk_i);
        rdchk(`SARC_IDX_STAT, 32'h20);
        // Values software programs for AC-97 operation
        apb(1'b1, `SARC_IDX_RXCLK, 32'h00001800);
        apb(1'b1, `SARC_IDX_RXCTL, 32'h00000F00);
        rdchk(`SARC_IDX_RXCLK, 32'h00001800);
        rdchk(`SARC_IDX_RXCTL, 32'h00000F00);
        stop_test();
    end
endmodule // sarc_rx_tb
